// File: logic/rcp_pkg.sv
package rcp_pkg;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 4;
   localparam int unsigned TMR_BITS      = 11;
   localparam int unsigned TMR_PERIODS   = 2048;
   // internal rc period as printed, in us
   localparam int unsigned RC_PERIOD_US  = 32;
   localparam int unsigned RC_PERIOD_CYC =
      (RC_PERIOD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned RC_DIV_BITS   = 13;

   // ------------------------------------------------------------
   // addresses and reset values
   // ------------------------------------------------------------
   localparam int unsigned PC_W        = 21;
   localparam logic [20:0] PC_RESET    = 21'h00_0000;
   localparam logic [20:0] PC_STEP     = 21'h00_0002;
   localparam logic [20:0] VEC_HIGH    = 21'h00_0008;
   localparam logic [20:0] VEC_LOW     = 21'h00_0018;
   localparam logic [4:0]  SP_RESET    = 5'h00;
   localparam logic [7:0]  BYTE_ZERO   = 8'h00;
   localparam logic [4:0]  TOP_OF_STACK_UPPER_ZERO   = 5'h00;
   localparam logic [5:0]  TBLU_ZERO   = 6'h00;
   localparam logic        FLAG_SET    = 1'b1;
   localparam logic        FLAG_CLR    = 1'b0;

   // ------------------------------------------------------------
   // sequencer states
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      RCP_POR  = 4'b0001,
      RCP_TMR  = 4'b0010,
      RCP_HOLD = 4'b0100,
      RCP_RUN  = 4'b1000
   } rcp_state_t;

   // power mode of the core at the moment of an event
   typedef enum logic [1:0] {
      RCP_MODE_FULL  = 2'h0,
      RCP_MODE_RUN   = 2'h1,
      RCP_MODE_IDLE  = 2'h2
   } rcp_mode_t;
endpackage

// File: logic/rcp_sync.sv
`timescale 1ns/100ps
// two-flop synchroniser for one asynchronous level
module rcp_sync
   import rcp_pkg::*;
#(
   parameter logic RESET_VAL = 1'b0
) (
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   input  wire logic d_i,
   output logic      q_o
);
   typedef struct packed {
      logic s1;
      logic s2;
   } rcp_sync_st_t;

   rcp_sync_st_t st;
   rcp_sync_st_t next_st;

   // first stage feeds only the second
   always_comb begin
      next_st.s1 = d_i;
      next_st.s2 = st.s1;
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         st <= '{s1: RESET_VAL, s2: RESET_VAL};
      end else begin
         st <= next_st;
      end
   end

   assign q_o = st.s2;
endmodule

// File: logic/rcp_top.sv
//
// Functional notes
// - brown-out or power-on clears brownout flag
// - regulator off blocks brown-out resets
// - timer always on, starts after por
// - 11-bit timer, 2048 rc periods
// - internal reset held while timer counts
// - master clear release after timer: run now
// - undefined registers kept over non-por resets
// - watchdog wake leaves registers unchanged
// - power-on loads pc zero, sets flags
// - soft reset and brown-out flag updates
// - master clear in run mode sets timeout
// - master clear idle sets timeout, clears pd
// - watchdog run reset clears timeout flag
// - full-power master clear keeps all flags
// - stack-full reset sets full flag
// - stack-underflow reset sets underflow flag
// - underflow without enable flags, no reset
// - watchdog in idle wakes, clears to, pd
// - interrupt wake clears pd, vectors if enabled
// - non-wake resets clear pointers and latches
// - power-on and brown-out flags set only by firmware
`timescale 1ns/100ps
module rcp_top
   import rcp_pkg::*;
#(
   parameter int unsigned RC_DIV = RC_PERIOD_CYC
) (
   input  wire logic              clk_i,
   input  wire logic              rst_n_i,
   input  wire logic              por_pulse_i,
   input  wire logic              brownout_i,
   input  wire logic              regulator_en_i,
   input  wire logic              master_clear_n,
   input  wire logic              watchdog_timeout_i,
   input  wire logic              soft_reset_i,
   input  wire logic              stack_full_i,
   input  wire logic              stack_underflow_i,
   input  wire logic              stack_overflow_reset_enable,
   input  wire logic              int_wake_i,
   input  wire logic              int_high_i,
   input  wire logic              global_int_enable_high,
   input  wire logic              global_int_enable_low,
   input  wire logic [1:0]        power_mode_i,
   input  wire logic [PC_W-1:0]   pc_i,
   input  wire logic              fw_set_por_i,
   input  wire logic              fw_set_bor_i,
   input  wire logic              fw_set_ri_i,
   input  wire logic              clrwdt_i,
   input  wire logic              sleep_i,
   input  wire logic              fw_clr_stack_i,
   output logic                   core_reset_o,
   output logic                   pc_load_o,
   output logic [PC_W-1:0]        pc_o,
   output logic                   latch_clear_o,
   output logic [4:0]             stack_pointer_reg_o,
   output logic                   power_on_flag_n_o,
   output logic                   brownout_flag_n_o,
   output logic                   soft_reset_flag_n_o,
   output logic                   watchdog_timeout_flag_n_o,
   output logic                   power_down_flag_n_o,
   output logic                   stack_full_flag_o,
   output logic                   stack_underflow_flag_o
);
   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic master_clear_n_n;
   logic por_s;
   logic bor_s;
   logic reg_en_s;

   // external pins first cross two flops; master clear idles high
   rcp_sync #(.RESET_VAL(1'b1)) u_sync_master_clear_n (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .d_i     (master_clear_n),
      .q_o     (master_clear_n_n)
   );
   rcp_sync #(.RESET_VAL(1'b1)) u_sync_por (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .d_i     (por_pulse_i),
      .q_o     (por_s)
   );
   rcp_sync #(.RESET_VAL(1'b0)) u_sync_bor (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .d_i     (brownout_i),
      .q_o     (bor_s)
   );
   rcp_sync #(.RESET_VAL(1'b1)) u_sync_reg (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .d_i     (regulator_en_i),
      .q_o     (reg_en_s)
   );

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      rcp_state_t           fsm;
      logic [RC_DIV_BITS-1:0] div;
      logic [TMR_BITS-1:0]  tmr;
      logic                 core_rst;
      logic                 pc_load;
      logic [PC_W-1:0]      pc;
      logic                 latch_clr;
      logic [4:0]           sp;
      logic                 por_n;
      logic                 bor_n;
      logic                 ri_n;
      logic                 to_n;
      logic                 pd_n;
      logic                 stack_full_flag;
      logic                 stack_underflow_flag;
   } rcp_st_t;

   rcp_st_t st;
   rcp_st_t next_st;

   logic bor_evt;
   logic por_evt;
   logic master_clear_n_evt;
   logic wdt_rst;
   logic wdt_wake;
   logic stk_rst;
   logic unf_err;
   logic int_en;
   logic idle_md;
   logic rc_tick;

   // brown-out only counts while the regulator is on
   assign bor_evt  = bor_s && reg_en_s;
   assign por_evt  = por_s;
   assign idle_md  = (power_mode_i == RCP_MODE_IDLE);
   assign master_clear_n_evt = !master_clear_n_n && (st.fsm == RCP_RUN);
   assign wdt_rst  = watchdog_timeout_i && !idle_md;
   assign wdt_wake = watchdog_timeout_i && idle_md;
   assign stk_rst  = (stack_full_i || stack_underflow_i)
                     && stack_overflow_reset_enable;
   assign unf_err  = stack_underflow_i && !stack_overflow_reset_enable;
   assign int_en   = global_int_enable_high || global_int_enable_low;
   assign rc_tick  = (st.div == RC_DIV_BITS'(RC_DIV - 1));

   // ------------------------------------------------------------
   // sequencer and flag update
   // ------------------------------------------------------------
   // priority: power-on, brown-out, then run-time events; flags
   // not named by an event keep their value
   always_comb begin
      next_st           = st;
      next_st.pc_load   = 1'b0;
      next_st.latch_clr = 1'b0;
      // firmware raises the active-low flags; sleep clears pd
      if (fw_set_por_i) next_st.por_n = FLAG_SET;
      if (fw_set_bor_i) next_st.bor_n = FLAG_SET;
      if (fw_set_ri_i)  next_st.ri_n  = FLAG_SET;
      if (clrwdt_i) begin
         next_st.to_n = FLAG_SET;
         next_st.pd_n = FLAG_SET;
      end
      if (sleep_i) begin
         next_st.to_n = FLAG_SET;
         next_st.pd_n = FLAG_CLR;
      end
      if (fw_clr_stack_i) begin
         next_st.stack_full_flag = FLAG_CLR;
         next_st.stack_underflow_flag = FLAG_CLR;
      end
      if (por_evt || bor_evt) begin
         // any new supply event restarts the timer from zero
         next_st.fsm       = por_evt ? RCP_POR : RCP_TMR;
         next_st.div       = '0;
         next_st.tmr       = '0;
         next_st.core_rst  = 1'b1;
         next_st.pc        = PC_RESET;
         next_st.latch_clr = 1'b1;
         next_st.sp        = SP_RESET;
         next_st.ri_n      = FLAG_SET;
         next_st.to_n      = FLAG_SET;
         next_st.pd_n      = FLAG_SET;
         next_st.bor_n     = FLAG_CLR;
         if (por_evt) begin
            next_st.por_n  = FLAG_CLR;
            next_st.stack_full_flag = FLAG_CLR;
            next_st.stack_underflow_flag = FLAG_CLR;
         end
      end else begin
         unique case (st.fsm)
            RCP_POR: begin
               // timer waits for the power-on pulse to clear
               next_st.fsm = RCP_TMR;
            end
            RCP_TMR: begin
               next_st.core_rst = 1'b1;
               next_st.div = rc_tick ? '0 : st.div + 1'b1;
               if (rc_tick) begin
                  next_st.tmr = st.tmr + 1'b1;
                  if (st.tmr == TMR_BITS'(TMR_PERIODS - 1)) begin
                     next_st.fsm = RCP_HOLD;
                  end
               end
            end
            RCP_HOLD: begin
               // held only by master clear; leaves with no delay
               if (master_clear_n_n) begin
                  next_st.fsm      = RCP_RUN;
                  next_st.core_rst = 1'b0;
                  next_st.pc_load  = 1'b1;
               end
            end
            RCP_RUN: begin
               if (master_clear_n_evt || soft_reset_i || wdt_rst || stk_rst) begin
                  next_st.fsm       = RCP_HOLD;
                  next_st.core_rst  = 1'b1;
                  next_st.pc        = PC_RESET;
                  next_st.latch_clr = 1'b1;
                  next_st.sp        = SP_RESET;
               end
               if (master_clear_n_evt) begin
                  if (power_mode_i == RCP_MODE_RUN) begin
                     next_st.to_n = FLAG_SET;
                  end else if (idle_md) begin
                     next_st.to_n = FLAG_SET;
                     next_st.pd_n = FLAG_CLR;
                  end
                  // full power: flags left as they are
               end else if (soft_reset_i) begin
                  next_st.ri_n = FLAG_CLR;
               end else if (wdt_rst) begin
                  next_st.to_n = FLAG_CLR;
               end else if (stk_rst) begin
                  if (stack_full_i) next_st.stack_full_flag = FLAG_SET;
                  if (stack_underflow_i) begin
                     next_st.stack_underflow_flag = FLAG_SET;
                  end
               end else if (wdt_wake) begin
                  next_st.to_n    = FLAG_CLR;
                  next_st.pd_n    = FLAG_CLR;
                  next_st.pc      = pc_i + PC_STEP;
                  next_st.pc_load = 1'b1;
               end else if (int_wake_i) begin
                  next_st.pd_n    = FLAG_CLR;
                  next_st.pc_load = 1'b1;
                  if (int_en) begin
                     next_st.pc = int_high_i ? VEC_HIGH : VEC_LOW;
                  end else begin
                     next_st.pc = pc_i + PC_STEP;
                  end
               end
               // underflow without reset still leaves its mark
               if (unf_err) next_st.stack_underflow_flag = FLAG_SET;
            end
            default: next_st.fsm = RCP_POR;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         st <= '{fsm: RCP_POR, div: '0, tmr: '0, core_rst: 1'b1,
                 pc_load: 1'b0, pc: PC_RESET, latch_clr: 1'b1,
                 sp: SP_RESET, por_n: FLAG_CLR, bor_n: FLAG_CLR,
                 ri_n: FLAG_SET, to_n: FLAG_SET, pd_n: FLAG_SET,
                 stack_full_flag: FLAG_CLR, stack_underflow_flag: FLAG_CLR};
      end else begin
         st <= next_st;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   // all outputs are state flops
   assign core_reset_o              = st.core_rst;
   assign pc_load_o                 = st.pc_load;
   assign pc_o                      = st.pc;
   assign latch_clear_o             = st.latch_clr;
   assign stack_pointer_reg_o       = st.sp;
   assign power_on_flag_n_o         = st.por_n;
   assign brownout_flag_n_o         = st.bor_n;
   assign soft_reset_flag_n_o       = st.ri_n;
   assign watchdog_timeout_flag_n_o = st.to_n;
   assign power_down_flag_n_o       = st.pd_n;
   assign stack_full_flag_o         = st.stack_full_flag;
   assign stack_underflow_flag_o    = st.stack_underflow_flag;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   chk_bor_clears: assert property (
      (por_evt || bor_evt) |=> !brownout_flag_n_o)
      else $error("brownout flag not cleared");
   chk_por_flags: assert property (
      por_evt |=> (!power_on_flag_n_o && !stack_full_flag_o
                   && soft_reset_flag_n_o && pc_o == PC_RESET))
      else $error("power-on flags wrong");
   chk_tmr_hold: assert property (
      (st.fsm == RCP_TMR) |-> core_reset_o)
      else $error("reset released during timer");
   chk_reg_off: assert property (
      (bor_s && !reg_en_s && !por_evt && st.fsm == RCP_RUN)
      |=> st.fsm != RCP_TMR)
      else $error("brown-out with regulator off");
   chk_master_clear_n_fast: assert property (
      (st.fsm == RCP_HOLD && master_clear_n_n && !por_evt && !bor_evt)
      |=> !core_reset_o)
      else $error("release delayed");
   chk_soft_ri: assert property (
      (st.fsm == RCP_RUN && soft_reset_i && !master_clear_n_evt
       && !clrwdt_i && !sleep_i && !por_evt && !bor_evt)
      |=> (!soft_reset_flag_n_o && $stable(watchdog_timeout_flag_n_o)))
      else $error("soft reset flag");
   chk_wdt_wake: assert property (
      (st.fsm == RCP_RUN && wdt_wake && !master_clear_n_evt && !soft_reset_i
       && !stk_rst && !por_evt && !bor_evt)
      |=> (!watchdog_timeout_flag_n_o && !power_down_flag_n_o
           && pc_o == $past(pc_i) + PC_STEP && !core_reset_o))
      else $error("watchdog wake wrong");
   chk_unf_err: assert property (
      (st.fsm == RCP_RUN && unf_err && !master_clear_n_evt && !soft_reset_i
       && !wdt_rst && !por_evt && !bor_evt)
      |=> (stack_underflow_flag_o && !core_reset_o))
      else $error("underflow error");
   chk_tmr_len: assert property (
      (st.fsm == RCP_POR && !por_evt && !bor_evt) ##1
      (st.fsm == RCP_TMR) |-> st.tmr == '0)
      else $error("timer not from zero");
   chk_tmr_stay: assert property (
      (st.fsm == RCP_TMR && st.tmr != TMR_BITS'(TMR_PERIODS - 1)
       && !por_evt && !bor_evt) |=> st.fsm == RCP_TMR)
      else $error("timer left early");

   cov_power_up: cover property (st.fsm == RCP_TMR ##1 st.fsm == RCP_HOLD);
   cov_run: cover property (st.fsm == RCP_HOLD ##1 st.fsm == RCP_RUN);
   cov_int: cover property (st.fsm == RCP_RUN && int_wake_i && int_en);
   cov_wdt_wake: cover property (st.fsm == RCP_RUN && wdt_wake);
endmodule

// File: tb/tb.sv
`timescale 1ns/100ps
module tb;
   import rcp_pkg::*;
   // short rc divider keeps the power-up wait near 4k cycles
   localparam int unsigned RCD     = 2;
   localparam int          TMR_CYC = TMR_PERIODS * RCD;
   localparam int          CEIL    = 90000;
   logic clk_i = 0, rst_n_i = 0, por_pulse_i = 0, brownout_i = 0;
   logic regulator_en_i = 1, master_clear_n = 1, watchdog_timeout_i = 0;
   logic soft_reset_i = 0, stack_full_i = 0, stack_underflow_i = 0;
   logic stack_overflow_reset_enable = 0, int_wake_i = 0, int_high_i = 0;
   logic global_int_enable_high = 0, global_int_enable_low = 0;
   logic fw_set_por_i = 0, fw_set_bor_i = 0, fw_set_ri_i = 0;
   logic clrwdt_i = 0, sleep_i = 0, fw_clr_stack_i = 0;
   logic [1:0]      power_mode_i = 2'h0;
   logic [PC_W-1:0] pc_i = '0;
   logic core_reset_o, pc_load_o, latch_clear_o;
   logic power_on_flag_n_o, brownout_flag_n_o, soft_reset_flag_n_o;
   logic watchdog_timeout_flag_n_o, power_down_flag_n_o;
   logic stack_full_flag_o, stack_underflow_flag_o;
   logic [PC_W-1:0] pc_o, lpc;
   logic [4:0]      stack_pointer_reg_o;
   int err_total = 0, total_checks = 0, cyc = 0, npl = 0, nlc = 0, w;
   int m_por, m_bor, m_ri, m_to, m_pd, m_sf, m_su;

   rcp_top #(.RC_DIV(RCD)) DUT (
      .clk_i, .rst_n_i, .por_pulse_i, .brownout_i, .regulator_en_i,
      .master_clear_n, .watchdog_timeout_i, .soft_reset_i, .stack_full_i,
      .stack_underflow_i, .stack_overflow_reset_enable, .int_wake_i,
      .int_high_i, .global_int_enable_high, .global_int_enable_low,
      .power_mode_i, .pc_i, .fw_set_por_i, .fw_set_bor_i, .fw_set_ri_i,
      .clrwdt_i, .sleep_i, .fw_clr_stack_i, .core_reset_o, .pc_load_o,
      .pc_o, .latch_clear_o, .stack_pointer_reg_o, .power_on_flag_n_o,
      .brownout_flag_n_o, .soft_reset_flag_n_o, .watchdog_timeout_flag_n_o,
      .power_down_flag_n_o, .stack_full_flag_o, .stack_underflow_flag_o);

   // ------------------------------------------------------------
   // clock, monitor and hang guard
   // ------------------------------------------------------------
   always #2 clk_i = ~clk_i;

   // one-cycle pulses are counted at the edge that samples them
   always @(posedge clk_i) begin
      cyc++;
      if (pc_load_o === 1'b1) begin
         npl++;
         lpc = pc_o;
      end
      if (latch_clear_o === 1'b1) nlc++;
      if (cyc == CEIL) begin
         err_total++;
         results();
      end
   end

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // flags in port order, active-low cause flags first
   task automatic chk_flags();
      chk({power_on_flag_n_o, brownout_flag_n_o, soft_reset_flag_n_o,
           watchdog_timeout_flag_n_o, power_down_flag_n_o,
           stack_full_flag_o, stack_underflow_flag_o},
          {m_por[0], m_bor[0], m_ri[0], m_to[0], m_pd[0], m_sf[0],
           m_su[0]});
   endtask

   task automatic por_model();
      {m_por, m_bor, m_ri, m_to, m_pd, m_sf, m_su} = {7{32'd0}};
      {m_ri, m_to, m_pd} = {32'd1, 32'd1, 32'd1};
   endtask

   task automatic clr_pulses();
      {watchdog_timeout_i, soft_reset_i, stack_full_i} = 3'b000;
      {stack_underflow_i, int_wake_i, fw_set_por_i} = 3'b000;
      {fw_set_bor_i, fw_set_ri_i, clrwdt_i, sleep_i} = 4'b0000;
      fw_clr_stack_i = 0;
   endtask

   task automatic wait_run(input int lim);
      w = 0;
      while (core_reset_o !== 1'b0 && w < lim) begin
         tick(1);
         w++;
      end
   endtask

   // firmware-side flag writes, mirrored in the model
   task automatic fw(input int r);
      case (r)
         0: begin fw_set_por_i = 1; m_por = 1; end
         1: begin fw_set_bor_i = 1; m_bor = 1; end
         2: begin fw_set_ri_i = 1; m_ri = 1; end
         3: begin clrwdt_i = 1; m_to = 1; m_pd = 1; end
         4: begin sleep_i = 1; m_to = 1; m_pd = 0; end
         default: begin fw_clr_stack_i = 1; m_sf = 0; m_su = 0; end
      endcase
      tick(1);
      clr_pulses();
   endtask

   // opt: bit0 stack reset / regulator, bit1 gie high, bit2 vector
   // select, bit3 gie low
   task automatic do_ev(input int k, input int mode, input int opt);
      int n0, l0, rst, load, nl;
      logic [PC_W-1:0] pcv, epc;
      fw($urandom % 6);
      tick(4);
      power_mode_i = mode[1:0];
      stack_overflow_reset_enable = opt[0];
      global_int_enable_high = opt[1];
      int_high_i = opt[2];
      global_int_enable_low = opt[3];
      pcv = PC_W'($urandom) & 21'h1f_fffe;
      pc_i = pcv;
      if (k == 6) regulator_en_i = opt[0];
      tick(2);
      n0 = npl;
      l0 = nlc;
      rst = 1;
      load = 1;
      epc = PC_RESET;
      case (k)
         0: begin soft_reset_i = 1; m_ri = 0; end
         1: begin
            watchdog_timeout_i = 1;
            m_to = 0;
            if (mode == 2) begin m_pd = 0; rst = 0; epc = pcv + PC_STEP; end
         end
         2: begin
            master_clear_n = 0;
            if (mode != 0) m_to = 1;
            if (mode == 2) m_pd = 0;
         end
         3: begin stack_full_i = 1; m_sf = 1; end
         4: begin stack_underflow_i = 1; m_su = 1; rst = opt[0]; end
         5: begin
            int_wake_i = 1;
            m_pd = 0;
            rst = 0;
            epc = pcv + PC_STEP;
            if (opt[1] | opt[3]) epc = opt[2] ? VEC_HIGH : VEC_LOW;
         end
         default: begin
            brownout_i = 1;
            if (opt[0]) begin m_ri = 1; m_to = 1; m_pd = 1; m_bor = 0; end
            else rst = 0;
         end
      endcase
      if (k == 4 || k == 6) load = rst;
      // every edge that still sees the brown-out level restarts and
      // clears again; the level stands four edges
      nl = (k == 6 && rst) ? 4 : rst;
      tick(1);
      clr_pulses();
      tick(3);
      master_clear_n = 1;
      brownout_i = 0;
      tick(8);
      wait_run(TMR_CYC + 1000);
      tick(2);
      chk_flags();
      chk(nlc - l0, nl);
      chk(core_reset_o, 0);
      chk(npl - n0, load);
      if (load) chk(lpc, epc);
      if (rst) chk(stack_pointer_reg_o, SP_RESET);
      regulator_en_i = 1;
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      void'($urandom(97));
      tick(6);
      rst_n_i = 1;
      por_model();
      wait_run(TMR_CYC + 1000);
      chk(w >= TMR_CYC, 1);
      chk(w <= TMR_CYC + 40, 1);
      tick(2);
      chk_flags();
      chk(lpc, PC_RESET);
      fw(0);
      fw(1);
      tick(2);
      chk_flags();
      $display("test powerup done");
      do_ev(0, 0, 0);
      do_ev(1, 0, 0);
      do_ev(1, 1, 0);
      do_ev(1, 2, 0);
      do_ev(2, 0, 0);
      do_ev(2, 1, 0);
      do_ev(2, 2, 0);
      do_ev(3, 0, 1);
      do_ev(4, 0, 1);
      do_ev(4, 0, 0);
      do_ev(5, 2, 0);
      do_ev(5, 2, 2);
      do_ev(5, 2, 6);
      do_ev(5, 2, 8);
      do_ev(6, 0, 1);
      do_ev(6, 0, 0);
      $display("test events done");
      // random mix; a stack-full without enable has no defined effect
      for (int i = 0; i < 24; i++) begin
         w = $urandom % 16;
         do_ev($urandom % 7, $urandom % 3, w | 1);
      end
      $display("test random done");
      // brown-out again while the timer runs restarts it
      brownout_i = 1;
      tick(4);
      brownout_i = 0;
      tick(1000);
      brownout_i = 1;
      tick(4);
      brownout_i = 0;
      {m_ri, m_to, m_pd, m_bor} = {32'd1, 32'd1, 32'd1, 32'd0};
      wait_run(TMR_CYC + 1000);
      chk(w >= TMR_CYC, 1);
      tick(2);
      chk_flags();
      $display("test restart done");
      // master clear held low past timer expiry, then released
      master_clear_n = 0;
      por_pulse_i = 1;
      tick(4);
      por_pulse_i = 0;
      por_model();
      tick(TMR_CYC + 200);
      chk(core_reset_o, 1);
      master_clear_n = 1;
      wait_run(20);
      chk(w <= 6, 1);
      tick(2);
      chk_flags();
      chk(lpc, PC_RESET);
      $display("test hold done");
      results();
   end
endmodule
